// ==== design/ddf_defines.svh ====
/*
  timing counts, fixed offsets and command codes for the dual-die flash host.
  assumes a 100 ns controller clock and 16-bit word addressing on the flash.
*/
`ifndef DDF_DEFINES_SVH
`define DDF_DEFINES_SVH

`define DDF_CLK_PERIOD_NS 100
`define DDF_CYC_UP(ns) (((ns) + `DDF_CLK_PERIOD_NS - 1) / `DDF_CLK_PERIOD_NS)

// access, write pulse, reset pulse and ready-busy valid times
`define DDF_T_ACC_NS 110
`define DDF_T_WP_NS 35
`define DDF_T_RP_NS 200
`define DDF_T_BUSY_NS 500
`define DDF_ACC_CYC `DDF_CYC_UP(`DDF_T_ACC_NS)
`define DDF_WP_CYC `DDF_CYC_UP(`DDF_T_WP_NS)
`define DDF_RP_CYC `DDF_CYC_UP(`DDF_T_RP_NS)
`define DDF_BUSY_CYC `DDF_CYC_UP(`DDF_T_BUSY_NS)
`define DDF_SYNC_LAT 3

// address layout
`define DDF_ADDR_W 27
`define DDF_DIE_BIT 26
`define DDF_SECT_LSB 16
`define DDF_SECT_BITS 10
`define DDF_DATA_W 16

// command offsets and data
`define DDF_OFS_UNLOCK1 11'h555
`define DDF_OFS_UNLOCK2 11'h2AA
`define DDF_DAT_UNLOCK1 16'h00AA
`define DDF_DAT_UNLOCK2 16'h0055
`define DDF_DAT_ERASE_SETUP 16'h0080
`define DDF_DAT_SECT_ERASE 16'h0030
`define DDF_DAT_ID_ENTER 16'h0090
`define DDF_DAT_ID_EXIT 16'h00F0
`define DDF_OFS_PROT_VERIFY 16'h0002

// last step index per operation
`define DDF_LAST_READ 3'h0
`define DDF_LAST_ERASE 3'h5
`define DDF_LAST_ID 3'h4

`endif

// ==== design/ddf_pkg.sv ====
/*
  types for the dual-die flash host.
  assumes nothing beyond the defines header.
*/
package ddf_pkg;
  typedef enum logic [1:0] {
    DDF_OP_READ = 2'h0,
    DDF_OP_ERASE = 2'h1,
    DDF_OP_ID = 2'h2,
    DDF_OP_PROT = 2'h3
  } ddf_op_e;

  typedef enum logic [2:0] {
    DDF_ST_IDLE = 3'h0,
    DDF_ST_SETUP = 3'h1,
    DDF_ST_STROBE = 3'h3,
    DDF_ST_HOLD = 3'h2,
    DDF_ST_NEXT = 3'h6,
    DDF_ST_WAIT = 3'h7,
    DDF_ST_RESET = 3'h5
  } ddf_state_e;
endpackage : ddf_pkg

// ==== design/ddf_sync.sv ====
/*
  three-flop pin synchroniser; the output follows once stages two and three agree.
  assumes pins asynchronous to ref_clk and an active-low async reset.
*/
`timescale 1ns/100ps
module ddf_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level_q
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] level_d;

  // per bit: follow only when stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      assign level_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : level_q[gi];
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      level_q <= INIT;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
    end
  end
endmodule : ddf_sync

// ==== design/ddf_host.sv ====
/*
  host controller for a two-die parallel flash behind one chip select:
  array reads, sector erase, identification and protect-verify reads.
  assumes the flash pins are wired directly; dq is resolved outside from dq_oe_n.
*/
`timescale 1ns/100ps
`include "ddf_defines.svh"
module ddf_host
  import ddf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic cmd_die,
  input wire logic [25:0] cmd_addr,
  input wire logic [3:0] cmd_id_ofs,
  input wire logic hw_reset_req,
  input wire logic wp_enable,
  output logic cmd_ready_q,
  output logic rsp_valid_q,
  output logic [15:0] rsp_data_q,
  output logic [26:0] flash_addr_q,
  output logic [15:0] dq_out_q,
  output logic dq_oe_n_q,
  input wire logic [15:0] dq_in,
  output logic ce_n_q,
  output logic oe_n_q,
  output logic we_n_q,
  output logic flash_reset_n_q,
  output logic wp_n_q,
  input wire logic ready_busy_n
);
  ////////////////////////////////////////////////////////////////////////////
  ddf_state_e st_q;
  ddf_state_e st_d;
  logic [1:0] op_q;
  logic die_q;
  logic [25:0] addr_q;
  logic [3:0] id_ofs_q;
  logic [2:0] step_q;
  logic [7:0] cnt_q;
  logic [15:0] dq_s;
  logic rb_s;

  ddf_sync #(.WIDTH(1), .INIT(1'b1)) u_rb_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pin(ready_busy_n),
    .level_q(rb_s)
  );
  ddf_sync #(.WIDTH(16), .INIT(16'h0000)) u_dq_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pin(dq_in),
    .level_q(dq_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // step table: die base on every command address
  wire [26:0] die_base = {die_q, 26'h0000000};
  wire [26:0] a_unl1 = die_base | {16'h0000, `DDF_OFS_UNLOCK1};
  wire [26:0] a_unl2 = die_base | {16'h0000, `DDF_OFS_UNLOCK2};
  wire [26:0] a_sect = {die_q, addr_q[25:`DDF_SECT_LSB], 16'h0000};
  wire [26:0] a_enter = (op_q == DDF_OP_PROT) ? (a_sect | {16'h0000, `DDF_OFS_UNLOCK1}) : a_unl1;
  wire [26:0] a_idrd = (op_q == DDF_OP_PROT) ? (a_sect | {11'h000, `DDF_OFS_PROT_VERIFY})
                                             : (die_base | {23'h000000, id_ofs_q});
  wire [26:0] a_array = {die_q, addr_q};
  wire is_read_op = (op_q == DDF_OP_READ);
  wire is_erase_op = (op_q == DDF_OP_ERASE);
  wire [2:0] last_step = is_read_op ? `DDF_LAST_READ : (is_erase_op ? `DDF_LAST_ERASE : `DDF_LAST_ID);
  wire unl1 = (step_q == 3'h0) || (is_erase_op && step_q == 3'h3);
  wire unl2 = (step_q == 3'h1) || (is_erase_op && step_q == 3'h4);
  wire step_read = is_read_op || (!is_erase_op && step_q == 3'h3);
  wire [26:0] step_addr = is_read_op ? a_array :
                          unl1 ? a_unl1 :
                          unl2 ? a_unl2 :
                          is_erase_op ? ((step_q == 3'h2) ? a_unl1 : a_sect) :
                          (step_q == 3'h2) ? a_enter :
                          (step_q == 3'h3) ? a_idrd : die_base;
  wire [15:0] step_data = unl1 ? `DDF_DAT_UNLOCK1 :
                          unl2 ? `DDF_DAT_UNLOCK2 :
                          is_erase_op ? ((step_q == 3'h2) ? `DDF_DAT_ERASE_SETUP : `DDF_DAT_SECT_ERASE) :
                          (step_q == 3'h2) ? `DDF_DAT_ID_ENTER : `DDF_DAT_ID_EXIT;
  wire [7:0] strobe_cyc = step_read ? 8'(`DDF_ACC_CYC + `DDF_SYNC_LAT) : 8'(`DDF_WP_CYC);
  wire cnt_done = (cnt_q == 8'h01);
  wire take_cmd = (st_q == DDF_ST_IDLE) && cmd_valid && !hw_reset_req;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      DDF_ST_IDLE: begin
        if (hw_reset_req) begin
          st_d = DDF_ST_RESET;
        end else if (cmd_valid) begin
          st_d = DDF_ST_SETUP;
        end
      end
      DDF_ST_SETUP: st_d = DDF_ST_STROBE;
      DDF_ST_STROBE: st_d = cnt_done ? DDF_ST_HOLD : DDF_ST_STROBE;
      DDF_ST_HOLD: st_d = DDF_ST_NEXT;
      DDF_ST_NEXT: begin
        if (step_q != last_step) begin
          st_d = DDF_ST_SETUP;
        end else begin
          st_d = is_erase_op ? DDF_ST_WAIT : DDF_ST_IDLE;
        end
      end
      DDF_ST_WAIT: st_d = (cnt_q == 8'h00 && rb_s) ? DDF_ST_IDLE : DDF_ST_WAIT;
      DDF_ST_RESET: st_d = cnt_done ? DDF_ST_IDLE : DDF_ST_RESET;
      default: st_d = DDF_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= DDF_ST_RESET;
      cnt_q <= 8'(`DDF_RP_CYC);
    end else begin
      st_q <= st_d;
      if (st_q == DDF_ST_SETUP) begin
        cnt_q <= strobe_cyc;
      end else if (st_q == DDF_ST_NEXT) begin
        cnt_q <= 8'(`DDF_BUSY_CYC + `DDF_SYNC_LAT);
      end else if (take_cmd || st_q == DDF_ST_HOLD) begin
        cnt_q <= 8'h00;
      end else if (st_q == DDF_ST_IDLE && hw_reset_req) begin
        cnt_q <= 8'(`DDF_RP_CYC);
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      op_q <= 2'h0;
      die_q <= 1'b0;
      addr_q <= 26'h0000000;
      id_ofs_q <= 4'h0;
      step_q <= 3'h0;
    end else if (take_cmd && !hw_reset_req) begin
      op_q <= cmd_op;
      die_q <= cmd_die;
      addr_q <= cmd_addr;
      id_ofs_q <= cmd_id_ofs;
      step_q <= 3'h0;
    end else if (st_q == DDF_ST_NEXT && step_q != last_step) begin
      step_q <= step_q + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive: one shared chip select, both dies see every write
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      flash_addr_q <= 27'h0000000;
      dq_out_q <= 16'h0000;
      dq_oe_n_q <= 1'b1;
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
    end else begin
      if (st_q == DDF_ST_SETUP) begin
        flash_addr_q <= step_addr;
        dq_out_q <= step_read ? 16'h0000 : step_data;
        dq_oe_n_q <= step_read;
      end else if (st_q == DDF_ST_NEXT) begin
        dq_oe_n_q <= 1'b1;
      end
      ce_n_q <= !(st_d == DDF_ST_SETUP || st_d == DDF_ST_STROBE || st_d == DDF_ST_HOLD);
      oe_n_q <= !(st_d == DDF_ST_STROBE && step_read);
      we_n_q <= !(st_d == DDF_ST_STROBE && !step_read);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      flash_reset_n_q <= 1'b0;
      wp_n_q <= 1'b0;
      cmd_ready_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 16'h0000;
    end else begin
      flash_reset_n_q <= (st_d != DDF_ST_RESET);
      wp_n_q <= !wp_enable;
      cmd_ready_q <= (st_d == DDF_ST_IDLE);
      rsp_valid_q <= (st_q != DDF_ST_IDLE && st_q != DDF_ST_RESET && st_d == DDF_ST_IDLE);
      if (st_q == DDF_ST_STROBE && cnt_done && step_read) begin
        rsp_data_q <= dq_s;
      end else if (take_cmd) begin
        rsp_data_q <= 16'h0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic we_prev_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      we_prev_q <= 1'b1;
    end else begin
      we_prev_q <= we_n_q;
    end
  end
  wire wr_start = we_prev_q && !we_n_q;
  AST_UNLOCK1: assert property (@(posedge ref_clk) disable iff (!nrst)
    wr_start && dq_out_q == `DDF_DAT_UNLOCK1 |-> flash_addr_q[10:0] == `DDF_OFS_UNLOCK1)
    else $error("first unlock write at wrong offset");
  AST_UNLOCK2: assert property (@(posedge ref_clk) disable iff (!nrst)
    wr_start && dq_out_q == `DDF_DAT_UNLOCK2 |-> flash_addr_q[10:0] == `DDF_OFS_UNLOCK2)
    else $error("second unlock write at wrong offset");
  AST_DIE_BASE: assert property (@(posedge ref_clk) disable iff (!nrst)
    wr_start |-> flash_addr_q[`DDF_DIE_BIT] == die_q)
    else $error("command write lacks die base");
  AST_ERASE_SECT: assert property (@(posedge ref_clk) disable iff (!nrst)
    wr_start && dq_out_q == `DDF_DAT_SECT_ERASE |-> flash_addr_q[15:0] == 16'h0000 && !dq_oe_n_q)
    else $error("erase confirm not at sector start");
  AST_ERASE_WAIT: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(we_n_q) && dq_out_q == `DDF_DAT_SECT_ERASE |-> ##[1:3] st_q == DDF_ST_WAIT)
    else $error("erase confirm not followed by busy wait");
  AST_ARG_DIE: assert property (@(posedge ref_clk) disable iff (!nrst)
    wr_start && is_erase_op && step_q == 3'h5 |-> flash_addr_q[26:16] == {die_q, addr_q[25:16]})
    else $error("sector argument routed to wrong die");
  AST_RSP_DIE: assert property (@(posedge ref_clk) disable iff (!nrst)
    $fell(oe_n_q) && !is_read_op |-> flash_addr_q[`DDF_DIE_BIT] == die_q && dq_oe_n_q)
    else $error("response read on wrong die");
  AST_READ_HOLD: assert property (@(posedge ref_clk) disable iff (!nrst)
    $fell(oe_n_q) |-> !oe_n_q [*5] ##1 oe_n_q)
    else $error("read strobe length wrong");
  AST_RESET_PULSE: assert property (@(posedge ref_clk) disable iff (!nrst)
    $fell(flash_reset_n_q) |-> !flash_reset_n_q [*2] ##1 flash_reset_n_q)
    else $error("flash reset pulse length wrong");
  AST_READY_WAIT: assert property (@(posedge ref_clk) disable iff (!nrst)
    st_q == DDF_ST_WAIT && !rb_s |=> st_q == DDF_ST_WAIT)
    else $error("left busy wait while flash busy");

  COV_ERASE: cover property (@(posedge ref_clk) disable iff (!nrst)
    st_q == DDF_ST_WAIT ##1 st_q == DDF_ST_IDLE);
  COV_ID_DIE1: cover property (@(posedge ref_clk) disable iff (!nrst)
    $fell(oe_n_q) && op_q == DDF_OP_ID && die_q);
  COV_PROT: cover property (@(posedge ref_clk) disable iff (!nrst)
    rsp_valid_q && op_q == DDF_OP_PROT);
endmodule : ddf_host

// ==== sim/ddf_flash_model.sv ====
/*
  two-die flash partner on one chip select: array, sector erase, id and protect verify.
  assumes the host pins of the controller; this model drives ready-busy both high and low.
*/
`timescale 1ns/100ps
module ddf_flash_model #(
  parameter logic [63:0] IDS = 64'h0,
  parameter logic [15:0] VFY = 16'h003F
) (
  input wire logic [26:0] flash_addr_q,
  input wire logic [15:0] dq_out_q,
  input wire logic dq_oe_n_q,
  input wire logic ce_n_q,
  input wire logic oe_n_q,
  input wire logic we_n_q,
  input wire logic flash_reset_n_q,
  input wire logic wp_n_q,
  input wire logic slow,
  output logic [15:0] dq_in,
  output logic ready_busy_n
);
  logic [2:0] step [2];
  logic id [2];
  bit erased [int];
  logic [15:0] last;
  wire d = flash_addr_q[26];
  wire [9:0] s = flash_addr_q[25:16];
  wire drive = !ce_n_q && !oe_n_q && flash_reset_n_q && dq_oe_n_q;
  wire u1 = flash_addr_q[10:0] == 11'h555 && dq_out_q == 16'h00AA;
  wire u2 = flash_addr_q[10:0] == 11'h2AA && dq_out_q == 16'h0055;

  function automatic logic [15:0] rd(input logic [26:0] a);
    if (id[a[26]]) begin
      case (a[3:0])
        4'h0: return IDS[63:48];
        4'h1: return IDS[47:32];
        4'hE: return IDS[31:16];
        4'hF: return IDS[15:0];
        4'h3: return VFY;
        4'h2: return {15'h0, a[25:16] == 10'h0 || a[25:16] == 10'h3FF};
        default: return 16'h0000;
      endcase
    end
    return erased.exists(a[26:16]) ? 16'hFFFF : a[15:0] ^ {5'h0, a[26:16]};
  endfunction : rd

  ////////////////////////////////////////
  // read data, released bus shows inverse
  initial ready_busy_n = 1'b1;
  always @* if (drive) last = rd(flash_addr_q);
  assign #60 dq_in = !dq_oe_n_q ? dq_out_q : drive ? rd(flash_addr_q) : ~last;

  ////////////////////////////////////////
  // command state per die
  always @(posedge we_n_q or negedge flash_reset_n_q) begin
    if (!flash_reset_n_q) begin
      step = '{3'h0, 3'h0};
      id = '{1'b0, 1'b0};
      ready_busy_n = 1'b1;
    end else if (!ce_n_q) begin
      if (dq_out_q == 16'h00F0) begin
        step[d] = 3'h0;
        id[d] = 1'b0;
      end else begin
        case (step[d])
          3'h0, 3'h3: step[d] = u1 ? step[d] + 3'h1 : 3'h0;
          3'h1, 3'h4: step[d] = u2 ? step[d] + 3'h1 : 3'h0;
          3'h2: begin
            id[d] = dq_out_q == 16'h0090;
            step[d] = dq_out_q == 16'h0080 ? 3'h3 : 3'h0;
          end
          default: begin
            step[d] = 3'h0;
            if (dq_out_q == 16'h0030 && (wp_n_q || (s != 10'h0 && s != 10'h3FF))) begin
              erased[flash_addr_q[26:16]] = 1'b1;
              ready_busy_n = 1'b0;
              ready_busy_n <= #(slow ? 20000 : 1000) 1'b1;
            end
          end
        endcase
      end
    end
  end
endmodule : ddf_flash_model

// ==== sim/testbench.sv ====
/*
  self-checking bench for the dual-die flash host: reads, erases, id and protect reads.
  assumes the partner in ddf_flash_model.sv and a 10 MHz clock.
*/
`timescale 1ns/100ps
`define CHK(g, e) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("ERROR %0t: got %h expected %h", $time, (g), (e)); \
  end \
end
module testbench;
  import ddf_pkg::*;
  localparam logic [63:0] IDS = 64'h00A5_1357_2468_9ACE; // arbitrary codes
  localparam logic [15:0] VFY = 16'h003F;
  localparam logic [3:0] OFS [5] = '{4'h0, 4'h1, 4'hE, 4'hF, 4'h3};
  localparam logic [15:0] IDV [5] = '{IDS[63:48], IDS[47:32], IDS[31:16], IDS[15:0], VFY};
  logic ref_clk, nrst, cmd_valid, cmd_die, hw_reset_req, wp_enable, slow, fl;
  logic [1:0] cmd_op;
  logic [25:0] cmd_addr;
  logic [3:0] cmd_id_ofs;
  logic cmd_ready_q, rsp_valid_q, dq_oe_n_q, ce_n_q, oe_n_q, we_n_q, flash_reset_n_q, wp_n_q, ready_busy_n;
  logic [15:0] rsp_data_q, dq_out_q, dq_in, d;
  logic [26:0] flash_addr_q, ra;
  logic [42:0] wq [$];
  bit erased_ref [int];
  int failures = 0;
  int check_count = 0;
  integer seed = 8;

  ddf_host ddf_host_i (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .cmd_valid(cmd_valid),
    .cmd_op(cmd_op),
    .cmd_die(cmd_die),
    .cmd_addr(cmd_addr),
    .cmd_id_ofs(cmd_id_ofs),
    .hw_reset_req(hw_reset_req),
    .wp_enable(wp_enable),
    .cmd_ready_q(cmd_ready_q),
    .rsp_valid_q(rsp_valid_q),
    .rsp_data_q(rsp_data_q),
    .flash_addr_q(flash_addr_q),
    .dq_out_q(dq_out_q),
    .dq_oe_n_q(dq_oe_n_q),
    .dq_in(dq_in),
    .ce_n_q(ce_n_q),
    .oe_n_q(oe_n_q),
    .we_n_q(we_n_q),
    .flash_reset_n_q(flash_reset_n_q),
    .wp_n_q(wp_n_q),
    .ready_busy_n(ready_busy_n)
  );
  ddf_flash_model #(.IDS(IDS), .VFY(VFY)) ddf_flash_model_i (
    .flash_addr_q(flash_addr_q),
    .dq_out_q(dq_out_q),
    .dq_oe_n_q(dq_oe_n_q),
    .ce_n_q(ce_n_q),
    .oe_n_q(oe_n_q),
    .we_n_q(we_n_q),
    .flash_reset_n_q(flash_reset_n_q),
    .wp_n_q(wp_n_q),
    .slow(slow),
    .dq_in(dq_in),
    .ready_busy_n(ready_busy_n)
  );

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge we_n_q) if (!ce_n_q) wq.push_back({flash_addr_q, dq_out_q});

  ////////////////////////////////////////
  function automatic logic [15:0] exp_arr(input logic [26:0] a);
    return erased_ref.exists(a[26:16]) ? 16'hFFFF : a[15:0] ^ {5'h0, a[26:16]};
  endfunction : exp_arr

  task automatic do_cmd(input logic [1:0] op, input logic die, input logic [25:0] a, input logic [3:0] o,
                        output logic [15:0] r);
    int n;
    n = 0;
    while (cmd_ready_q !== 1'b1) @(negedge ref_clk);
    wq.delete();
    cmd_op = op;
    cmd_die = die;
    cmd_addr = a;
    cmd_id_ofs = o;
    cmd_valid = 1'b1;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    while (rsp_valid_q !== 1'b1 && n < 1000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 1000) begin
      failures++;
      $display("ERROR %0t: no response to command", $time);
      stop_test();
    end
    r = rsp_data_q;
  endtask : do_cmd

  task automatic erase(input logic die, input logic [9:0] s);
    logic [42:0] e [6];
    logic [15:0] w;
    e = '{{die, 15'h0, 11'h555, 16'h00AA}, {die, 15'h0, 11'h2AA, 16'h0055}, {die, 15'h0, 11'h555, 16'h0080},
          {die, 15'h0, 11'h555, 16'h00AA}, {die, 15'h0, 11'h2AA, 16'h0055}, {die, s, 16'h0000, 16'h0030}};
    do_cmd(2'h1, die, {s, 16'h0000}, 4'h0, d);
    `CHK(wq.size(), 6)
    foreach (e[i]) `CHK(wq[i], e[i])
    `CHK(ready_busy_n, 1'b1)
    `CHK(wp_n_q, !wp_enable)
    if (!wp_enable || (s != 10'h0 && s != 10'h3FF)) erased_ref[{die, s}] = 1'b1;
    w = 16'($random(seed));
    do_cmd(2'h0, die, {s, w}, 4'h0, d);
    `CHK(d, exp_arr({die, s, w}))
    do_cmd(2'h0, !die, {s, w}, 4'h0, d);
    `CHK(d, exp_arr({!die, s, w}))
  endtask : erase

  task automatic stop_test;
    $display("failures=%0d checks=%0d", failures, check_count);
    if (failures == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  ////////////////////////////////////////
  initial begin
    #(100 * 20000);
    failures++;
    $display("ERROR %0t: watchdog expired", $time);
    stop_test();
  end

  initial begin
    {nrst, cmd_valid, cmd_die, hw_reset_req, wp_enable, slow} = 6'h00;
    cmd_op = 2'h0;
    cmd_addr = 26'h0;
    cmd_id_ofs = 4'h0;
    repeat (12) @(negedge ref_clk);
    nrst = 1'b1;
    // array reads across the die boundary
    for (int i = 0; i < 8; i++) begin
      ra = i == 0 ? 27'h3FFFFFF : i == 1 ? 27'h4000000 : 27'($random(seed));
      do_cmd(2'h0, ra[26], ra[25:0], 4'h0, d);
      `CHK(d, exp_arr(ra))
    end
    // erases, prompt and slow busy, write protect
    erase(1'b0, ra[25:16]);
    slow = 1'b1;
    erase(1'b1, 10'h3FF);
    wp_enable = 1'b1;
    erase(1'b0, 10'h000);
    erase(1'b1, 10'h000);
    erase(1'b0, 10'h155);
    wp_enable = 1'b0;
    // id words on both dies
    for (int k = 0; k < 10; k++) begin
      do_cmd(2'h2, k >= 5, 26'h0, OFS[k % 5], d);
      `CHK(d, IDV[k % 5])
      `CHK(wq[2], {k >= 5, 15'h0, 11'h555, 16'h0090})
    end
    // protect verify
    for (int k = 0; k < 6; k++) begin
      ra = 27'($random(seed));
      if (k % 3 == 0) ra[25:16] = 10'h000;
      if (k % 3 == 1) ra[25:16] = 10'h3FF;
      do_cmd(2'h3, k[0], ra[25:0], 4'h0, d);
      `CHK(d, {15'h0, ra[25:16] == 10'h0 || ra[25:16] == 10'h3FF})
    end
    // hardware reset then array read
    while (cmd_ready_q !== 1'b1) @(negedge ref_clk);
    hw_reset_req = 1'b1;
    fl = 1'b0;
    repeat (4) begin
      @(negedge ref_clk);
      hw_reset_req = 1'b0;
      fl |= flash_reset_n_q === 1'b0;
    end
    `CHK(fl, 1'b1)
    do_cmd(2'h0, 1'b1, 26'h0123, 4'h0, d);
    `CHK(d, exp_arr(27'h4000123))
    stop_test();
  end
endmodule : testbench
